// >>> common/dspm_params.svh
// Constants for the dual six-bit pulse modulator: register offsets, fields, resets.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DSPM_PARAMS_SVH
`define DSPM_PARAMS_SVH

// --------------------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------------------
`define DSPM_OFF_CTRL_A 4'h0
`define DSPM_OFF_CTRL_B 4'h4
`define DSPM_OFF_DUTY_A 4'h8
`define DSPM_OFF_DUTY_B 4'hC
`define DSPM_OFF_WAIT 4'h0
`define DSPM_ADDR_W 4

// --------------------------------------------------------------------------
// Control and duty field positions and masks
// --------------------------------------------------------------------------
`define DSPM_CTL_DIV_LSB 0
`define DSPM_CTL_DIV_MSB 3
`define DSPM_CTL_SEL_LSB 4
`define DSPM_CTL_SEL_MSB 5
`define DSPM_DUTY_POL_BIT 7
`define DSPM_DUTY_MSB 5
`define DSPM_CTL_MASK 8'h3F
`define DSPM_DUTY_MASK 8'hBF

// --------------------------------------------------------------------------
// Encodings, counts and reset values
// --------------------------------------------------------------------------
`define DSPM_SEL_OFF 2'h0
`define DSPM_SEL_DIV1 2'h1
`define DSPM_SEL_DIV8 2'h2
`define DSPM_SEL_DIV16 2'h3
`define DSPM_DIV8_LAST 4'h7
`define DSPM_DIV16_LAST 4'hF
`define DSPM_CNT_LAST 6'h3F
`define DSPM_CTL_RESET 8'h00
`define DSPM_RESP_OKAY 2'h0
`define DSPM_RESP_SLVERR 2'h2

`endif

// >>> common/dspm_pkg.sv
// Types shared by the dual six-bit pulse modulator.
// Assumes the constants header sits in the include path.
`default_nettype none

package dspm_pkg;
  `include "dspm_params.svh"

  typedef logic [1:0] dspm_sel_t;
  typedef logic [3:0] dspm_div_t;
  typedef logic [5:0] dspm_duty_t;
  typedef logic [7:0] dspm_byte_t;
  typedef logic [`DSPM_ADDR_W-1:0] dspm_addr_t;
endpackage : dspm_pkg

`default_nettype wire

// >>> core/dspm_top.sv
// Dual six-bit pulse modulator with an AXI4-Lite register slave.
// Assumes one 100 MHz clock, synchronous active-high reset, and that STOP_MODE halts it.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
`include "dspm_params.svh"

// Notes on behaviour
// - Written duty waits in a buffer and loads at the end of the period.
// - Reading duty returns the active value, not the buffered one.
// - Control and duty registers are readable and writable at any time.
// - First-stage select: off, divide by one, eight or sixteen.
// - Second stage divides the first-stage clock by its value plus one.
// - Nonzero channel A select makes its port pin carry channel A.
// - Nonzero channel B select makes its port pin carry channel B.
// - Channel B fields behave exactly as channel A fields.
// - Each channel holds a six-bit duty that reset leaves unchanged.
// - Duty zero gives a steady level set by polarity.
// - Polarity one gives active-high pulses, zero active-low pulses.
// - Channels keep running while the processor waits.
// - Stop mode freezes channels at whatever phase they reached.
// - Reset clears first-stage selects, disabling channels and driving outputs low.
// - A six-bit modulus counter divides the prescaled clock by 64.
// - Largest duty gives 63 of 64 active counts.
// - While disabled, a written duty goes active immediately.
module dspm_top (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic STOP_MODE,
  input wire logic [1:0] PORT_DATA,
  input wire logic [1:0] PORT_DIR,
  output logic [1:0] PORT_PIN_O,
  output logic [1:0] PORT_PIN_OE,
  output logic [1:0] CHANNEL_OUT,
  input wire dspm_pkg::dspm_addr_t S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire dspm_pkg::dspm_addr_t S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import dspm_pkg::*;

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  dspm_byte_t ctrl_reg [2];
  dspm_duty_t duty_active_reg [2];
  dspm_duty_t duty_buf_reg [2];
  logic pol_reg [2];
  logic buf_pend_reg [2];
  logic [1:0] out_reg;
  logic [1:0] pin_o_reg;
  logic [1:0] pin_oe_reg;

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  dspm_addr_t aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane0_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wr_fire;
  logic wr_hit [2][2];
  logic wr_ok;

  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_ok = (aw_addr_reg[1:0] == 2'h0);

  // --------------------------------------------------------------------------
  // Write address capture
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (S_AXI_AWVALID && awready_reg) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Write data capture
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_lane0_reg <= 1'b0;
    end else if (S_AXI_WVALID && wready_reg) begin
      w_held_reg <= 1'b1;
      w_data_reg <= S_AXI_WDATA[7:0];
      w_lane0_reg <= S_AXI_WSTRB[0];
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Write channel readiness
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
    end else begin
      awready_reg <= !aw_held_reg && !(S_AXI_AWVALID && awready_reg) && !bvalid_reg;
      wready_reg <= !w_held_reg && !(S_AXI_WVALID && wready_reg) && !bvalid_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Write response
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `DSPM_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? `DSPM_RESP_OKAY : `DSPM_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Channel logic, one copy per channel
  // --------------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      dspm_sel_t sel;
      dspm_div_t div;
      logic [3:0] first_cnt_reg;
      logic [3:0] second_cnt_reg;
      dspm_duty_t mod_cnt_reg;
      logic first_tick;
      logic second_tick;
      logic period_end;
      logic [3:0] first_last;
      logic active;

      // ----------------------------------------------------------------------
      // Register write decode
      // ----------------------------------------------------------------------
      assign sel = ctrl_reg[ch][`DSPM_CTL_SEL_MSB:`DSPM_CTL_SEL_LSB];
      assign div = ctrl_reg[ch][`DSPM_CTL_DIV_MSB:`DSPM_CTL_DIV_LSB];
      assign wr_hit[ch][0] = wr_fire && wr_ok && w_lane0_reg &&
        (aw_addr_reg == (ch == 0 ? `DSPM_OFF_CTRL_A : `DSPM_OFF_CTRL_B));
      assign wr_hit[ch][1] = wr_fire && wr_ok && w_lane0_reg &&
        (aw_addr_reg == (ch == 0 ? `DSPM_OFF_DUTY_A : `DSPM_OFF_DUTY_B));

      // ----------------------------------------------------------------------
      // Prescaler stages
      // ----------------------------------------------------------------------
      always_comb begin
        case (sel)
          `DSPM_SEL_DIV8: first_last = `DSPM_DIV8_LAST;
          `DSPM_SEL_DIV16: first_last = `DSPM_DIV16_LAST;
          default: first_last = 4'h0;
        endcase
      end

      // First stage ticks once per one, eight or sixteen cycles; frozen in stop.
      assign first_tick = (sel != `DSPM_SEL_OFF) && !STOP_MODE &&
        (first_cnt_reg == first_last);
      assign second_tick = first_tick && (second_cnt_reg == div);
      assign period_end = second_tick && (mod_cnt_reg == `DSPM_CNT_LAST);

      // ----------------------------------------------------------------------
      // Period counters
      // ----------------------------------------------------------------------
      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || sel == `DSPM_SEL_OFF) begin
          first_cnt_reg <= 4'h0;
          second_cnt_reg <= 4'h0;
          mod_cnt_reg <= 6'h00;
        end else if (first_tick) begin
          first_cnt_reg <= 4'h0;
          second_cnt_reg <= second_tick ? 4'h0 : second_cnt_reg + 4'h1;
          if (second_tick) begin
            mod_cnt_reg <= mod_cnt_reg + 6'h01;
          end
        end else if (!STOP_MODE) begin
          first_cnt_reg <= first_cnt_reg + 4'h1;
        end
      end

      // ----------------------------------------------------------------------
      // Control and polarity
      // ----------------------------------------------------------------------
      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
          ctrl_reg[ch] <= `DSPM_CTL_RESET;
          pol_reg[ch] <= 1'b0;
        end else begin
          if (wr_hit[ch][0]) begin
            ctrl_reg[ch] <= w_data_reg & `DSPM_CTL_MASK;
          end
          if (wr_hit[ch][1]) begin
            pol_reg[ch] <= w_data_reg[`DSPM_DUTY_POL_BIT];
          end
        end
      end

      // ----------------------------------------------------------------------
      // Duty buffer
      // ----------------------------------------------------------------------
      // Duty has no reset; the active duty loads from the buffer at period end, or from the write at once while off.
      always_ff @(posedge CLK_SYS) begin
        if (wr_hit[ch][1]) begin
          duty_buf_reg[ch] <= w_data_reg[`DSPM_DUTY_MSB:0];
        end
        if (wr_hit[ch][1] && sel == `DSPM_SEL_OFF) begin
          duty_active_reg[ch] <= w_data_reg[`DSPM_DUTY_MSB:0];
        end else if (period_end && buf_pend_reg[ch]) begin
          duty_active_reg[ch] <= duty_buf_reg[ch];
        end
      end

      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
          buf_pend_reg[ch] <= 1'b0;
        end else if (wr_hit[ch][1]) begin
          buf_pend_reg[ch] <= (sel != `DSPM_SEL_OFF);
        end else if (period_end) begin
          buf_pend_reg[ch] <= 1'b0;
        end
      end

      // ----------------------------------------------------------------------
      // Waveform output
      // ----------------------------------------------------------------------
      // Active while the count is below duty; duty zero never active.
      assign active = (mod_cnt_reg < duty_active_reg[ch]);

      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || sel == `DSPM_SEL_OFF) begin
          out_reg[ch] <= 1'b0;
        end else begin
          out_reg[ch] <= pol_reg[ch] ? active : !active;
        end
      end

      // ----------------------------------------------------------------------
      // Pin multiplexer
      // ----------------------------------------------------------------------
      // Pin mux: enabled channel owns the pin, else ordinary port data and direction.
      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
          pin_o_reg[ch] <= 1'b0;
          pin_oe_reg[ch] <= 1'b0;
        end else if (sel != `DSPM_SEL_OFF) begin
          pin_o_reg[ch] <= pol_reg[ch] ? active : !active;
          pin_oe_reg[ch] <= 1'b1;
        end else begin
          pin_o_reg[ch] <= PORT_DATA[ch];
          pin_oe_reg[ch] <= PORT_DIR[ch];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_next;
  logic rd_ok;

  // --------------------------------------------------------------------------
  // Read decode
  // --------------------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    rd_ok = 1'b1;
    case (S_AXI_ARADDR)
      `DSPM_OFF_CTRL_A: rdata_next[7:0] = ctrl_reg[0];
      `DSPM_OFF_CTRL_B: rdata_next[7:0] = ctrl_reg[1];
      `DSPM_OFF_DUTY_A: rdata_next[7:0] = {pol_reg[0], 1'b0, duty_active_reg[0]};
      `DSPM_OFF_DUTY_B: rdata_next[7:0] = {pol_reg[1], 1'b0, duty_active_reg[1]};
      default: rd_ok = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Read response
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `DSPM_RESP_OKAY;
    end else if (S_AXI_ARVALID && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rdata_next;
      rresp_reg <= rd_ok ? `DSPM_RESP_OKAY : `DSPM_RESP_SLVERR;
    end else if (rvalid_reg) begin
      if (S_AXI_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end else begin
      arready_reg <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign CHANNEL_OUT = out_reg;
  assign PORT_PIN_O = pin_o_reg;
  assign PORT_PIN_OE = pin_oe_reg;
  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY = wready_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

endmodule // dspm_top

`default_nettype wire

// >>> sim/dspm_top_properties.sv
// Checker on the ports of the dual six-bit pulse modulator.
// Assumes a bind from the bench, one clock and a synchronous reset.
`default_nettype none

// ------------------------------------------------------------
// Port properties
// ------------------------------------------------------------
module dspm_checker (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic STOP_MODE,
  input wire logic [1:0] PORT_DATA,
  input wire logic [1:0] PORT_DIR,
  input wire logic [1:0] PORT_PIN_O,
  input wire logic [1:0] PORT_PIN_OE,
  input wire logic [1:0] CHANNEL_OUT,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);
  a_reset_quiet: assert property (disable iff (1'b0)
    SYS_RST |=> CHANNEL_OUT == 2'h0 && PORT_PIN_OE == 2'h0) else $error("active after reset");
  a_pin_a_port: assert property (!PORT_PIN_OE[0] && !$past(SYS_RST) |->
    !$past(PORT_DIR[0]) && PORT_PIN_O[0] == $past(PORT_DATA[0])) else $error("pin A mux");
  a_pin_b_port: assert property (!PORT_PIN_OE[1] && !$past(SYS_RST) |->
    !$past(PORT_DIR[1]) && PORT_PIN_O[1] == $past(PORT_DATA[1])) else $error("pin B mux");
  a_stop_hold: assert property (STOP_MODE [*3] |-> $stable(CHANNEL_OUT))
    else $error("output moved in stop");
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID) else $error("no write response");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("no read data");
  a_busy_ready: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("ready while answering");
  a_resp_held: assert property ($fell(S_AXI_BVALID) |-> $past(S_AXI_BREADY))
    else $error("response dropped early");
  cover property (S_AXI_BVALID && S_AXI_BREADY);
  cover property ($rose(CHANNEL_OUT[0]));
  cover property ($rose(CHANNEL_OUT[1]));
endmodule // dspm_checker

`default_nettype wire

// >>> sim/test_dual_six_bit_pulse_modulator.sv
// Self-checking bench for the dual six-bit pulse modulator.
// Assumes package, design and checker are compiled before this file.
`default_nettype none
`include "dspm_params.svh"

// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module test_dual_six_bit_pulse_modulator;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] ok = `DSPM_RESP_OKAY;
  localparam logic [1:0] err = `DSPM_RESP_SLVERR;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stop = 1'b0;
  logic [1:0] pdata = 2'h0;
  logic [1:0] pdir = 2'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, pin_o, pin_oe, ch_out;
  logic [31:0] rdata;
  int n_errors = 0;
  int compares = 0;

  always #5 clk = ~clk;

  dspm_top dspm_top_inst (.CLK_SYS(clk), .SYS_RST(rst), .STOP_MODE(stop), .PORT_DATA(pdata),
    .PORT_DIR(pdir), .PORT_PIN_O(pin_o), .PORT_PIN_OE(pin_oe), .CHANNEL_OUT(ch_out),
    .S_AXI_AWADDR(addr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(addr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic hang();
    n_errors++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    end_of_test();
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int i;
    @(posedge clk);
    addr <= a;
    wdata <= 32'(d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (i == 40) hang();
    chk(32'(bresp), 32'(er), "write resp");
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int i;
    @(posedge clk);
    addr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (i == 40) hang();
    chk(32'(rresp), 32'(er), "read resp");
    if (er == ok) chk(rdata, 32'(d), "read data");
  endtask

  task automatic cfg(input int c, input logic [7:0] ctl, input logic [7:0] dty);
    wr(4'(4 * c), 8'h00, ok);
    wr(4'(8 + 4 * c), dty, ok);
    wr(4'(4 * c), ctl, ok);
    repeat (4) @(posedge clk);
  endtask

  task automatic wave(input int c, input logic pol, input int hi, input int per);
    int h, l, s;
    for (s = 0; s < 9000 && ch_out[c] === pol; s++) @(posedge clk);
    if (s == 9000) hang();
    for (s = 0; s < 9000 && ch_out[c] !== pol; s++) @(posedge clk);
    if (s == 9000) hang();
    for (h = 0; h < 9000 && ch_out[c] === pol; h++) @(posedge clk);
    for (l = 0; l < 9000 && ch_out[c] !== pol; l++) @(posedge clk);
    if (h == 9000 || l == 9000) hang();
    chk(h, hi, "active time");
    chk(h + l, per, "period");
  endtask

  task automatic steady(input int c, input logic lvl);
    int n = 0;
    repeat (300) begin
      @(posedge clk);
      if (ch_out[c] !== lvl) n++;
    end
    chk(n, 0, "steady level");
  endtask

  task automatic t_regs();
    chk(32'(ch_out), 32'h0000_0000, "out after reset");
    rd(4'h0, 8'h00, ok);
    rd(4'h4, 8'h00, ok);
    wr(4'h8, 8'h85, ok);
    rd(4'h8, 8'h85, ok);
    wr(4'hC, 8'hFF, ok);
    rd(4'hC, 8'hBF, ok);
    wr(4'h4, 8'hFF, ok);
    rd(4'h4, 8'h3F, ok);
    wr(4'h4, 8'h00, ok);
    wstrb <= 4'h0;
    wr(4'h0, 8'h11, ok);
    wstrb <= 4'hF;
    wr(4'h1, 8'h33, err);
    rd(4'h2, 8'h00, err);
    rd(4'h0, 8'h00, ok);
    pdata <= 2'h1;
    pdir <= 2'h2;
    repeat (3) @(posedge clk);
    chk(32'(pin_o), 32'h0000_0001, "port data");
    chk(32'(pin_oe), 32'h0000_0002, "port dir");
  endtask

  task automatic t_rates();
    logic [7:0] ctl [4] = '{8'h10, 8'h13, 8'h20, 8'h31};
    logic [7:0] dty [4] = '{8'h82, 8'hBF, 8'h85, 8'h81};
    int u;
    pdir <= 2'h0;
    foreach (ctl[k]) begin
      u = (ctl[k][5:4] == 2'h1 ? 1 : ctl[k][5:4] == 2'h2 ? 8 : 16) * (ctl[k][3:0] + 1);
      cfg(0, ctl[k], dty[k]);
      wave(0, 1'b1, int'(dty[k][5:0]) * u, 64 * u);
    end
    chk(32'(pin_oe[0]), 32'h0000_0001, "pin A enable");
    cfg(1, 8'h12, 8'h03);
    wave(1, 1'b0, 9, 192);
    chk(32'(pin_oe[1]), 32'h0000_0001, "pin B enable");
    chk(32'(pin_o), 32'(ch_out), "pins follow channels");
    cfg(0, 8'h10, 8'h80);
    steady(0, 1'b0);
    cfg(0, 8'h10, 8'h00);
    steady(0, 1'b1);
  endtask

  task automatic t_buffer();
    int i;
    wr(4'h4, 8'h00, ok);
    @(posedge clk);
    chk(32'(ch_out[1]), 32'h0000_0000, "idle channel off");
    cfg(0, 8'h10, 8'h82);
    for (i = 0; i < 200 && ch_out[0] !== 1'b1; i++) @(posedge clk);
    if (i == 200) hang();
    wr(4'h8, 8'h84, ok);
    rd(4'h8, 8'h82, ok);
    wave(0, 1'b1, 4, 64);
    rd(4'h8, 8'h84, ok);
  endtask

  task automatic t_stop();
    logic v;
    repeat (20) @(posedge clk);
    stop <= 1'b1;
    repeat (3) @(posedge clk);
    v = ch_out[0];
    steady(0, v);
    stop <= 1'b0;
    wave(0, 1'b1, 4, 64);
  endtask

  task automatic t_reset();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'(ch_out), 32'h0000_0000, "out in reset");
    rd(4'h0, 8'h00, ok);
    rd(4'h8, 8'h04, ok);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_rates();
    t_buffer();
    t_stop();
    t_reset();
    end_of_test();
  end
endmodule // test_dual_six_bit_pulse_modulator

bind dspm_top dspm_checker dspm_checker_inst (.CLK_SYS, .SYS_RST, .STOP_MODE, .PORT_DATA,
  .PORT_DIR, .PORT_PIN_O, .PORT_PIN_OE, .CHANNEL_OUT, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
  .S_AXI_ARREADY, .S_AXI_RVALID);

`default_nettype wire
